// File: pin_state_by_power_mode.v
// Pin state controller with AXI4-Lite register access.
`include "pin_state_defines.vh"
module pin_state_by_power_mode #(
  parameter NPINS = 8
) (
  input  wire             clk_i,              // System clock.
  input  wire             rst_n_i,            // Synchronous reset, low.
  input  wire [2:0]       power_state_i,      // Encoded power state.
  input  wire             external_reset_n_i, // Reset pin level.
  input  wire             osc_stop_i,         // Main oscillation stopped.
  input  wire [NPINS-1:0] pad_i,              // Pad input levels.
  input  wire [NPINS-1:0] per_out_i,          // Peripheral outputs.
  input  wire [NPINS-1:0] per_oe_i,           // Peripheral enables.
  input  wire [NPINS-1:0] per_run_i,          // Peripherals running.
  output reg  [NPINS-1:0] pad_o,              // Pad output values.
  output reg  [NPINS-1:0] pad_oe_o,           // Pad output enables.
  output reg  [NPINS-1:0] int_in_o,           // Gated internal inputs.
  output reg  [NPINS-1:0] gpio_owner_o,       // Port owns pin.
  output reg  [NPINS-1:0] wakeup_input_en_o,  // Wake-up input on.
  output reg  [NPINS-1:0] analog_en_o,        // Analog input on.
  output reg              xtal_in_en_o,       // Crystal inputs on.
  output reg              xout_oe_o,          // Oscillator out driven.
  output reg              xout_in_en_o,       // Oscillator out input.
  output reg              rst_pullup_o,       // Reset pin pull-up.
  output reg              rst_in_en_o,        // Reset pin input on.
  input  wire [7:0]       s_axi_awaddr,       // Write address.
  input  wire             s_axi_awvalid,      // Write address valid.
  output reg              s_axi_awready,      // Write address ready.
  input  wire [31:0]      s_axi_wdata,        // Write data.
  input  wire [3:0]       s_axi_wstrb,        // Write byte strobes.
  input  wire             s_axi_wvalid,       // Write data valid.
  output reg              s_axi_wready,       // Write data ready.
  output reg  [1:0]       s_axi_bresp,        // Write response.
  output reg              s_axi_bvalid,       // Write response valid.
  input  wire             s_axi_bready,       // Write response ready.
  input  wire [7:0]       s_axi_araddr,       // Read address.
  input  wire             s_axi_arvalid,      // Read address valid.
  output reg              s_axi_arready,      // Read address ready.
  output reg  [31:0]      s_axi_rdata,        // Read data.
  output reg  [1:0]       s_axi_rresp,        // Read response.
  output reg              s_axi_rvalid,       // Read data valid.
  input  wire             s_axi_rready        // Read data ready.
);

  // Software registers.
  reg  [31:0]      ctrl_r;
  reg  [31:0]      func_r;
  reg  [31:0]      gpio_out_r;
  reg  [31:0]      gpio_oe_r;
  // Write channel capture.
  reg  [7:0]       wr_addr_r;
  reg  [31:0]      wr_data_r;
  reg  [3:0]       wr_strb_r;
  reg              aw_have_r;
  reg              w_have_r;
  // Synchronised pins and effective state.
  wire             ext_rst_sync;
  wire [NPINS-1:0] pad_sync;
  reg  [2:0]       eff_state;
  // Per-pin decode results.
  wire [NPINS-1:0] c_out;
  wire [NPINS-1:0] c_oe;
  wire [NPINS-1:0] c_in_en;
  wire [NPINS-1:0] c_own;
  wire [NPINS-1:0] c_wake;
  wire [NPINS-1:0] c_ana;
  wire             aw_take;
  wire             w_take;
  wire             do_write;
  wire             ar_take;
  reg              xout_float;
  genvar           g;

  // Merge byte lanes of a write into the old register value.
  function [31:0] merge_strb;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer      k;
    begin
      merge_strb = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge_strb[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction

  // Tell whether a byte offset hits a mapped register.
  function is_mapped;
    input [7:0] addr;
    begin
      is_mapped = (addr == `OFS_CTRL) || (addr == `OFS_FUNC) ||
                  (addr == `OFS_GPIO_OUT) || (addr == `OFS_GPIO_OE) ||
                  (addr == `OFS_STATUS) || (addr == `OFS_PAD_IN);
    end
  endfunction

  // Reset pin and pad inputs come from outside the clock domain.
  pin_sync3 #(
    .WIDTH (1)
  ) u_rst_sync (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .rst_val_i (1'b0),
    .async_i   (external_reset_n_i),
    .sync_o    (ext_rst_sync)
  );

  pin_sync3 #(
    .WIDTH (NPINS)
  ) u_pad_sync (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .rst_val_i ({NPINS{1'b0}}),
    .async_i   (pad_i),
    .sync_o    (pad_sync)
  );

  // A low reset pin forces the external reset state after power-on.
  always @* begin
    eff_state = power_state_i;
    if (!ext_rst_sync && power_state_i != `PS_POR) begin
      eff_state = `PS_EXT_RESET;
    end
  end

  // One decode cell per general pin.
  generate
    for (g = 0; g < NPINS; g = g + 1) begin : g_pin
      pin_cell u_cell (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .state_i    (eff_state),
        .func_i     (func_r[g*3 +: 3]),
        .standby_pin_level_i (ctrl_r[`CTRL_LEVEL_BIT]),
        .gpio_out_i (gpio_out_r[g]),
        .gpio_oe_i  (gpio_oe_r[g]),
        .per_out_i  (per_out_i[g]),
        .per_oe_i   (per_oe_i[g]),
        .per_run_i  (per_run_i[g]),
        .out_o      (c_out[g]),
        .oe_o       (c_oe[g]),
        .in_en_o    (c_in_en[g]),
        .gpio_own_o (c_own[g]),
        .wake_en_o  (c_wake[g]),
        .ana_en_o   (c_ana[g])
      );
    end
  endgenerate

  // Oscillator output floats in reset and once oscillation stops.
  always @* begin
    xout_float = (eff_state == `PS_POR) ||
                 (eff_state == `PS_EXT_RESET) ||
                 (eff_state == `PS_INT_RESET) || osc_stop_i;
  end

  // Register the pin controls so every output comes from a flop.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pad_o             <= {NPINS{1'b0}};
      pad_oe_o          <= {NPINS{1'b0}};
      int_in_o          <= {NPINS{1'b0}};
      gpio_owner_o      <= {NPINS{1'b0}};
      wakeup_input_en_o <= {NPINS{1'b0}};
      analog_en_o       <= {NPINS{1'b0}};
      xtal_in_en_o      <= 1'b1;
      xout_oe_o         <= 1'b0;
      xout_in_en_o      <= 1'b0;
      rst_pullup_o      <= 1'b1;
      rst_in_en_o       <= 1'b1;
    end else begin
      pad_o             <= c_out & c_oe;
      pad_oe_o          <= c_oe;
      int_in_o          <= pad_sync & c_in_en;
      gpio_owner_o      <= c_own;
      wakeup_input_en_o <= c_wake;
      analog_en_o       <= c_ana;
      xtal_in_en_o      <= 1'b1;
      xout_oe_o         <= !xout_float;
      xout_in_en_o      <= !xout_float;
      rst_pullup_o      <= 1'b1;
      rst_in_en_o       <= 1'b1;
    end
  end

  assign aw_take  = s_axi_awvalid && s_axi_awready;
  assign w_take   = s_axi_wvalid && s_axi_wready;
  assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
  assign ar_take  = s_axi_arvalid && s_axi_arready;

  // Write path: address and data in either order, then one response.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      wr_addr_r     <= 8'h00;
      wr_data_r     <= 32'h00000000;
      wr_strb_r     <= 4'h0;
    end else begin
      if (aw_take) begin
        wr_addr_r     <= s_axi_awaddr;
        aw_have_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        wr_data_r    <= s_axi_wdata;
        wr_strb_r    <= s_axi_wstrb;
        w_have_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(wr_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Register writes; status and pad input are read only.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_r     <= `RST_CTRL;
      func_r     <= `RST_FUNC;
      gpio_out_r <= `RST_GPIO;
      gpio_oe_r  <= `RST_GPIO;
    end else if (do_write) begin
      case (wr_addr_r)
        `OFS_CTRL: begin
          ctrl_r <= merge_strb(ctrl_r, wr_data_r, wr_strb_r) &
                    32'h00000001;
        end
        `OFS_FUNC: begin
          func_r <= merge_strb(func_r, wr_data_r, wr_strb_r);
        end
        `OFS_GPIO_OUT: begin
          gpio_out_r <= merge_strb(gpio_out_r, wr_data_r, wr_strb_r);
        end
        `OFS_GPIO_OE: begin
          gpio_oe_r <= merge_strb(gpio_oe_r, wr_data_r, wr_strb_r);
        end
        default: begin
          ctrl_r <= ctrl_r;
        end
      endcase
    end
  end

  // Read path: one read at a time, data one cycle after the address.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= is_mapped(s_axi_araddr) ? `RESP_OKAY
                                                 : `RESP_SLVERR;
        s_axi_rdata   <= 32'h00000000;
        case (s_axi_araddr)
          `OFS_CTRL: begin
            s_axi_rdata <= ctrl_r;
          end
          `OFS_FUNC: begin
            s_axi_rdata <= func_r;
          end
          `OFS_GPIO_OUT: begin
            s_axi_rdata <= gpio_out_r;
          end
          `OFS_GPIO_OE: begin
            s_axi_rdata <= gpio_oe_r;
          end
          `OFS_STATUS: begin
            s_axi_rdata[`STAT_PS_LSB +: 3] <= eff_state;
            s_axi_rdata[`STAT_RST_BIT]     <= ext_rst_sync;
            s_axi_rdata[`STAT_OSC_BIT]     <= osc_stop_i;
          end
          `OFS_PAD_IN: begin
            s_axi_rdata[NPINS-1:0] <= int_in_o;
          end
          default: begin
            s_axi_rdata <= 32'h00000000;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // pin_state_by_power_mode

// File: pin_state_defines.vh
// Constants shared by the pin state controller files.
`ifndef PIN_STATE_DEFINES_VH
`define PIN_STATE_DEFINES_VH

// Power states reported by the reset and low-power controller.
`define PS_POR        3'h0
`define PS_EXT_RESET  3'h1
`define PS_INT_RESET  3'h2
`define PS_RUN        3'h3
`define PS_STANDBY    3'h4
`define PS_DEEP       3'h5
`define PS_RETURN     3'h6

// Per-pin function selection codes.
`define FN_GPIO       3'h0
`define FN_PERIPH     3'h1
`define FN_WAKEUP     3'h2
`define FN_ANALOG     3'h3
`define FN_EXTINT     3'h4

// Register byte offsets.
`define OFS_CTRL      8'h00
`define OFS_FUNC      8'h04
`define OFS_GPIO_OUT  8'h08
`define OFS_GPIO_OE   8'h0C
`define OFS_STATUS    8'h10
`define OFS_PAD_IN    8'h14

// Field positions.
`define CTRL_LEVEL_BIT 0
`define STAT_PS_LSB   0
`define STAT_RST_BIT  4
`define STAT_OSC_BIT  5

// Reset values.
`define RST_CTRL      32'h00000000
`define RST_FUNC      32'h00000000
`define RST_GPIO      32'h00000000

// AXI responses.
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// File: pin_sync3.v
// Three-stage input synchroniser that accepts a change once stages agree.
module pin_sync3 #(
  parameter WIDTH = 1
) (
  input  wire             clk_i,   // System clock.
  input  wire             rst_n_i, // Synchronous reset, active low.
  input  wire [WIDTH-1:0] rst_val_i, // Value taken in reset.
  input  wire [WIDTH-1:0] async_i, // Asynchronous inputs.
  output reg  [WIDTH-1:0] sync_o   // Filtered synchronous level.
);

  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;
  genvar g;

  // The first stage feeds only the second stage.
  always @(posedge clk_i) begin
    s1_r <= async_i;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // Each bit updates only when stages two and three agree.
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge clk_i) begin
        if (!rst_n_i) begin
          sync_o[g] <= rst_val_i[g];
        end else if (s2_r[g] == s3_r[g]) begin
          sync_o[g] <= s3_r[g];
        end
      end
    end
  endgenerate

endmodule // pin_sync3

// File: pin_cell.v
// State decode for one general pin: drive, input gate and owner.
`include "pin_state_defines.vh"
module pin_cell (
  input  wire       clk_i,      // System clock.
  input  wire       rst_n_i,    // Synchronous reset, active low.
  input  wire [2:0] state_i,    // Effective power state.
  input  wire [2:0] func_i,     // Function selection.
  input  wire       standby_pin_level_i, // Standby pin level.
  input  wire       gpio_out_i, // Port output value.
  input  wire       gpio_oe_i,  // Port output enable.
  input  wire       per_out_i,  // Peripheral output value.
  input  wire       per_oe_i,   // Peripheral output enable.
  input  wire       per_run_i,  // Peripheral still running.
  output reg        out_o,      // Pad output value.
  output reg        oe_o,       // Pad output enable.
  output reg        in_en_o,    // Digital input enabled.
  output reg        gpio_own_o, // Port owns the pin.
  output reg        wake_en_o,  // Wake-up input enabled.
  output reg        ana_en_o    // Analog input enabled.
);

  reg held_out_r;
  reg held_oe_r;
  reg held_gpio_r;
  reg hold;
  reg in_reset;

  // Capture the pin's driven state while running so standby can keep it.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      held_out_r  <= 1'b0;
      held_oe_r   <= 1'b0;
      held_gpio_r <= 1'b1;
    end else if (state_i == `PS_RUN) begin
      held_out_r  <= (func_i == `FN_PERIPH) ? per_out_i : gpio_out_i;
      held_oe_r   <= (func_i == `FN_PERIPH) ? per_oe_i : gpio_oe_i;
      held_gpio_r <= (func_i != `FN_PERIPH);
    end
  end

  // Decode the pin state from power state, function and standby level.
  always @* begin
    out_o      = 1'b0;
    oe_o       = 1'b0;
    in_en_o    = 1'b0;
    gpio_own_o = 1'b1;
    wake_en_o  = 1'b0;
    ana_en_o   = 1'b0;
    hold       = 1'b0;
    in_reset   = (state_i == `PS_POR) || (state_i == `PS_EXT_RESET) ||
                 (state_i == `PS_INT_RESET);
    if (func_i == `FN_ANALOG) begin
      ana_en_o = (state_i != `PS_POR);
    end else if (in_reset) begin
      // Port configuration is ignored; the driver stays off.
      gpio_own_o = 1'b0;
      if (func_i == `FN_PERIPH) begin
        in_en_o = (state_i != `PS_POR);
      end
    end else begin
      case (state_i)
        `PS_RUN: begin
          gpio_own_o = (func_i != `FN_PERIPH);
          out_o      = gpio_own_o ? gpio_out_i : per_out_i;
          oe_o       = gpio_own_o ? gpio_oe_i : per_oe_i;
          in_en_o    = 1'b1;
        end
        `PS_STANDBY: begin
          if (!standby_pin_level_i || func_i == `FN_WAKEUP ||
              func_i == `FN_EXTINT) begin
            hold = 1'b1;
          end
        end
        `PS_DEEP: begin
          wake_en_o = (func_i == `FN_WAKEUP);
          in_en_o   = wake_en_o;
          hold      = !standby_pin_level_i;
        end
        `PS_RETURN: begin
          hold = 1'b1;
        end
        default: begin
          hold = 1'b0;
        end
      endcase
      if (hold) begin
        // Keep the pre-entry state; a running peripheral keeps driving in standby only.
        in_en_o    = 1'b1 | wake_en_o;
        gpio_own_o = held_gpio_r;
        out_o      = held_out_r;
        oe_o       = held_oe_r;
        if (!held_gpio_r && per_run_i && state_i == `PS_STANDBY) begin
          out_o = per_out_i;
          oe_o  = per_oe_i;
        end
      end
      if (state_i == `PS_DEEP || state_i == `PS_RETURN) begin
        gpio_own_o = 1'b1;
      end
    end
  end

endmodule // pin_cell

// File: pin_state_chk.sv
// Checker of pin state and register bus behaviour at the top ports.
`include "pin_state_defines.vh"
module pin_state_chk #(
  parameter NPINS = 8
) (
  input logic             clk_i,              // Clock.
  input logic             rst_n_i,            // Reset, low.
  input logic [2:0]       power_state_i,      // Power state.
  input logic             external_reset_n_i, // Reset pin.
  input logic             osc_stop_i,         // Oscillation stopped.
  input logic [NPINS-1:0] pad_o,              // Pad values.
  input logic [NPINS-1:0] pad_oe_o,           // Pad enables.
  input logic [NPINS-1:0] int_in_o,           // Internal inputs.
  input logic [NPINS-1:0] gpio_owner_o,       // Port owner.
  input logic [NPINS-1:0] analog_en_o,        // Analog inputs.
  input logic             xtal_in_en_o,       // Crystal inputs.
  input logic             xout_oe_o,          // Oscillator out.
  input logic             xout_in_en_o,       // Oscillator input.
  input logic             rst_pullup_o,       // Reset pull-up.
  input logic             rst_in_en_o,        // Reset input.
  input logic             s_axi_arvalid,      // Read address valid.
  input logic             s_axi_arready,      // Read address ready.
  input logic             s_axi_rvalid,       // Read data valid.
  input logic             s_axi_bvalid,       // Write response valid.
  input logic             s_axi_bready        // Write response ready.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] hi_cnt_r;
  logic [3:0] lo_cnt_r;

  // Count, up to fifteen, how long the reset pin has stood at one level.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hi_cnt_r <= 4'h0;
      lo_cnt_r <= 4'h0;
    end else begin
      hi_cnt_r <= !external_reset_n_i ? 4'h0 :
                  hi_cnt_r + {3'h0, hi_cnt_r != 4'hF};
      lo_cnt_r <= external_reset_n_i ? 4'h0 :
                  lo_cnt_r + {3'h0, lo_cnt_r != 4'hF};
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Fixed and floating pin outputs, then pin outputs against the power state one clock earlier or the reset pin, then the read and write handshakes.
  a_xtal_on:
    assert property (xtal_in_en_o) else $error("crystal input off");
  a_rst_pin_up:
    assert property (rst_pullup_o && rst_in_en_o)
      else $error("reset pin pull-up or input off");
  a_float_quiet:
    assert property ((pad_o & ~pad_oe_o) == '0)
      else $error("undriven pad shows a value");
  a_analog_float:
    assert property (((int_in_o | pad_oe_o) & analog_en_o) == '0)
      else $error("analog pin driven or input open");
  a_reset_float:
    assert property ($past(power_state_i) <= 3'h2 |-> pad_oe_o == '0)
      else $error("pad driven in a reset state");
  a_xout_off:
    assert property (($past(power_state_i) <= 3'h2 || $past(osc_stop_i))
      |-> !xout_oe_o && !xout_in_en_o)
      else $error("oscillator output active in reset or stop");
  a_deep_port:
    assert property ($past(power_state_i) == `PS_DEEP && hi_cnt_r == 4'hF
      |-> &(gpio_owner_o | analog_en_o))
      else $error("pin not handed to port in deep standby");
  a_pin_reset:
    assert property (lo_cnt_r >= 4'h8 |-> pad_oe_o == '0)
      else $error("pad driven while reset pin low");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
  a_write_done:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not withdrawn");
endmodule // pin_state_chk

// File: pwr_ctrl_model.sv
// Behavioural reset and low-power controller driving the power inputs.
`include "pin_state_defines.vh"
module pwr_ctrl_model (
  input  logic       clk_i,              // Clock.
  input  logic [2:0] req_state_i,        // Requested power state.
  input  logic       pin_low_i,          // Pull the reset pin low.
  input  logic       stop_i,             // Stop main oscillation.
  output logic [2:0] power_state_o,      // Reported power state.
  output logic       external_reset_n_o, // Reset pin level.
  output logic       osc_stop_o          // Oscillation stopped.
);
  timeunit 1ns;
  timeprecision 1ns;

  // Start in power-on reset with the pin released.
  initial begin
    power_state_o = `PS_POR;
    external_reset_n_o = 1'b1;
    osc_stop_o = 1'b0;
  end

  // Levels change only just after a clock edge.
  always @(posedge clk_i) begin
    power_state_o <= req_state_i;
    external_reset_n_o <= !pin_low_i;
    osc_stop_o <= stop_i;
  end
endmodule // pwr_ctrl_model

// File: pin_state_by_power_mode_tb.sv
// Self-checking bench for the pin state controller.
`include "pin_state_defines.vh"
module pin_state_by_power_mode_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NP = 5;
  typedef struct packed {
    logic [2:0] st;
    logic       lvl;
    logic [4:0] m, oe, ie, om, own, wk, an;
  } row_t;
  row_t          rows [9];
  logic          clk_i = 1'b0;
  logic          rst_n_i = 1'b0;
  logic [2:0]    power_state_i;
  logic [2:0]    req_state = `PS_POR;
  logic          external_reset_n_i, osc_stop_i;
  logic          pin_low = 1'b0, stop_req = 1'b0;
  logic [NP-1:0] pad_i = '1, per_out_i = '1, per_oe_i = '1, per_run_i = '1;
  logic [NP-1:0] pad_o, pad_oe_o, int_in_o, gpio_owner_o;
  logic [NP-1:0] wakeup_input_en_o, analog_en_o;
  logic          xtal_in_en_o, xout_oe_o, xout_in_en_o;
  logic          rst_pullup_o, rst_in_en_o;
  logic [7:0]    s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]   s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]    s_axi_wstrb = 4'hF;
  logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic          s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic          s_axi_rready = 1'b0;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic          s_axi_arready, s_axi_rvalid;
  logic [1:0]    s_axi_bresp, s_axi_rresp, rs;
  int            n_errors = 0, n_tests = 0, cyc = 0;

  // Clock of 100 ns period.
  initial begin
    forever #50 clk_i = ~clk_i;
  end

  pwr_ctrl_model u_pwr_ctrl_model (.clk_i, .req_state_i(req_state),
    .pin_low_i(pin_low), .stop_i(stop_req), .power_state_o(power_state_i),
    .external_reset_n_o(external_reset_n_i), .osc_stop_o(osc_stop_i));

  pin_state_by_power_mode #(.NPINS(NP)) u_pin_state_by_power_mode (.clk_i,
    .rst_n_i, .power_state_i, .external_reset_n_i, .osc_stop_i, .pad_i,
    .per_out_i, .per_oe_i, .per_run_i, .pad_o, .pad_oe_o, .int_in_o,
    .gpio_owner_o, .wakeup_input_en_o, .analog_en_o, .xtal_in_en_o,
    .xout_oe_o, .xout_in_en_o, .rst_pullup_o, .rst_in_en_o, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bus write; both channels offered together, response held ready.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Bus read; data and response taken at the edge rvalid is seen.
  task automatic axr(input logic [7:0] a);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Requests a power state and waits for controller and decode.
  task automatic go(input logic [2:0] s);
    @(posedge clk_i);
    req_state <= s;
    repeat (3) @(posedge clk_i);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      stop_test();
    end
  end

  // Main sequence: registers, state table, then the awkward cases.
  initial begin
    rows = '{'{3'h0, 1'b0, 5'h1F, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00},
             '{3'h1, 1'b0, 5'h1F, 5'h00, 5'h02, 5'h00, 5'h00, 5'h00, 5'h08},
             '{3'h2, 1'b0, 5'h1F, 5'h00, 5'h02, 5'h00, 5'h00, 5'h00, 5'h08},
             '{3'h3, 1'b0, 5'h0B, 5'h03, 5'h03, 5'h03, 5'h01, 5'h00, 5'h08},
             '{3'h4, 1'b0, 5'h0B, 5'h03, 5'h03, 5'h00, 5'h00, 5'h00, 5'h08},
             '{3'h4, 1'b1, 5'h1F, 5'h14, 5'h14, 5'h00, 5'h00, 5'h00, 5'h08},
             '{3'h5, 1'b0, 5'h09, 5'h01, 5'h01, 5'h17, 5'h17, 5'h04, 5'h08},
             '{3'h5, 1'b1, 5'h0B, 5'h00, 5'h00, 5'h17, 5'h17, 5'h04, 5'h08},
             '{3'h6, 1'b0, 5'h09, 5'h01, 5'h01, 5'h17, 5'h17, 5'h00, 5'h08}};
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 16; a += 4) begin
      axr(a[7:0]);
      check("reset value", 32'h0, rd);
    end
    axw(`OFS_FUNC, 32'h00004688);
    axw(`OFS_GPIO_OUT, 32'h0000001F);
    axw(`OFS_GPIO_OE, 32'h0000001F);
    axr(`OFS_FUNC);
    check("func", 32'h00004688, rd);
    axw(`OFS_CTRL, 32'h00000001);
    axr(`OFS_CTRL);
    check("ctrl", 32'h00000001, rd);
    axr(8'h18);
    check("unmapped read resp", `RESP_SLVERR, rs);
    check("unmapped read data", 32'h0, rd);
    axw(8'h18, 32'hFFFFFFFF);
    check("unmapped write resp", `RESP_SLVERR, rs);
    axw(`OFS_STATUS, 32'hFFFFFFFF);
    check("status write resp", `RESP_OKAY, rs);
    foreach (rows[i]) begin
      axw(`OFS_CTRL, {31'h0, rows[i].lvl});
      go(rows[i].st);
      check("pad_oe", rows[i].oe, pad_oe_o & rows[i].m);
      check("pad_o", rows[i].oe, pad_o & rows[i].m);
      check("int_in", rows[i].ie, int_in_o & rows[i].m);
      check("owner", rows[i].own, gpio_owner_o & rows[i].om);
      check("wakeup", rows[i].wk, wakeup_input_en_o);
      check("analog", rows[i].an, analog_en_o);
    end
    axw(`OFS_CTRL, 32'h0);
    go(`PS_RUN);
    go(`PS_STANDBY);
    per_out_i <= 5'h1D;
    repeat (2) @(posedge clk_i);
    check("running peripheral", 1'b0, pad_o[1]);
    per_run_i <= 5'h1D;
    repeat (2) @(posedge clk_i);
    check("stopped peripheral", 1'b1, pad_o[1]);
    per_run_i <= 5'h1F;
    per_out_i <= 5'h1F;
    go(`PS_RUN);
    stop_req <= 1'b1;
    repeat (3) @(posedge clk_i);
    check("xout stopped", 2'h0, {xout_oe_o, xout_in_en_o});
    stop_req <= 1'b0;
    pin_low <= 1'b1;
    repeat (10) @(posedge clk_i);
    check("pin reset oe", 5'h00, pad_oe_o);
    check("pin reset in", 5'h02, int_in_o & 5'h0B);
    check("fixed pins", 3'h7,
          {xtal_in_en_o, rst_pullup_o, rst_in_en_o});
    axr(`OFS_STATUS);
    check("status", 32'h00000001, rd);
    axr(`OFS_PAD_IN);
    check("pad in reg", 32'h00000002, rd);
    pin_low <= 1'b0;
    repeat (10) @(posedge clk_i);
    check("pin released", 1'b1, pad_oe_o[0]);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check("mid reset oe", 5'h00, pad_oe_o);
    rst_n_i <= 1'b1;
    axr(`OFS_FUNC);
    check("func after reset", 32'h0, rd);
    stop_test();
  end
endmodule // pin_state_by_power_mode_tb

bind pin_state_by_power_mode pin_state_chk #(.NPINS(NPINS)) u_pin_state_chk (
  .clk_i, .rst_n_i, .power_state_i, .external_reset_n_i, .osc_stop_i, .pad_o,
  .pad_oe_o, .int_in_o, .gpio_owner_o, .analog_en_o, .xtal_in_en_o,
  .xout_oe_o, .xout_in_en_o, .rst_pullup_o, .rst_in_en_o, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready);
